// *** rtl/ccg_defines.svh ***
`ifndef CCG_DEFINES_SVH
`define CCG_DEFINES_SVH

// register offsets on the local register port
`define CCG_CTRL_OFFSET      8'h00
`define CCG_STAT_OFFSET      8'h04
// control register layout
`define CCG_CTRL_RESET       8'h00
`define CCG_CTRL_MASK        8'hF0
`define CCG_STOP_EN_BIT      7
`define CCG_WAKE_MSB         6
`define CCG_WAKE_LSB         4
// wake level encodings
`define CCG_WAKE_ANY         3'h0
`define CCG_WAKE_2           3'h1
`define CCG_WAKE_4           3'h2
`define CCG_WAKE_5           3'h5
`define CCG_WAKE_6           3'h6
`define CCG_WAKE_NONE        3'h7
// strap encodings
`define CCG_RATIO_QUARTER    2'h0
`define CCG_RATIO_HALF       2'h2
`define CCG_RATIO_THIRD      2'h3
`define CCG_RANGE_UNUSED     2'h3
// status register bit positions
`define CCG_STAT_LOCKED      7
`define CCG_STAT_STOPPED     6
`define CCG_STAT_RATIO_OK    5
`define CCG_STAT_SHORT_RST   4
// timing counts
`define CCG_LOCK_REF_CYCLES  100000
`define CCG_RESET_IN_N_MIN_REF     7'd80
`define CCG_RESET_OUT_N_BUS_CYCLES  5'd16
`define CCG_CORE_PER_REF     3'd2

`endif

// *** rtl/ccg_pkg.sv ***
package ccg_pkg;

    typedef enum logic [1:0] {
        mode_reset,
        mode_lock,
        mode_run,
        mode_stop
    } ccg_mode_type;

endpackage : ccg_pkg

// *** rtl/ccg_top.sv ***
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "ccg_defines.svh"

module ccg_top #(
    parameter int unsigned LOCK_REF_CYCLES = `CCG_LOCK_REF_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ref_clock_in,
    input  wire logic       reset_in_n,
    input  wire logic [3:0] data_pins,
    input  wire logic       stop_request,
    input  wire logic [2:0] irq_level,
    input  wire logic       watchdog_reset,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic            core_clock_out,
    output logic            core_clock_run,
    output logic            trace_status_clock,
    output logic            bus_clock_out,
    output logic            reset_out_n,
    output logic      [1:0] loop_range,
    output logic            loop_locked
);

    localparam logic [16:0] LOCK_LAST = 17'(LOCK_REF_CYCLES - 1);

    // pin synchronisers
    logic [1:0]         ref_sync_q;
    logic               ref_prev_q;
    logic [1:0]         rstn_sync_q;
    logic               rstn_prev_q;
    logic [3:0]         pin_s1_q;
    logic [3:0]         pin_s2_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_sync_q  <= 2'h0;
            ref_prev_q  <= 1'b0;
            rstn_sync_q <= 2'h0;
            rstn_prev_q <= 1'b0;
            pin_s1_q    <= 4'h0;
            pin_s2_q    <= 4'h0;
        end else begin
            ref_sync_q  <= {ref_sync_q[0], ref_clock_in};
            ref_prev_q  <= ref_sync_q[1];
            rstn_sync_q <= {rstn_sync_q[0], reset_in_n};
            rstn_prev_q <= rstn_sync_q[1];
            pin_s1_q    <= data_pins;
            pin_s2_q    <= pin_s1_q;
        end
    end

    wire ref_rise      = ref_sync_q[1] & ~ref_prev_q;
    wire rst_in_active = ~rstn_sync_q[1];
    wire rst_release   = rstn_sync_q[1] & ~rstn_prev_q;

    // strap capture: follow the pins during reset, freeze on release
    logic [3:0]         strap_hold_q;
    logic [1:0]         range_q;
    logic [1:0]         ratio_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_hold_q <= 4'h0;
            range_q      <= 2'h0;
            ratio_q      <= `CCG_RATIO_QUARTER;
        end else begin
            if (rst_in_active) begin
                strap_hold_q <= pin_s2_q;
            end
            if (rst_release) begin
                range_q <= strap_hold_q[3:2];
                ratio_q <= strap_hold_q[1:0];
            end
        end
    end

    // range drives the analog loop band; it stays put through stop
    assign loop_range = range_q;

    // reset-length check against the reference clock
    logic [6:0]         reset_in_n_cnt_q;
    logic               short_rst_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_in_n_cnt_q  <= 7'h00;
            short_rst_q <= 1'b0;
        end else begin
            if (!rst_in_active) begin
                reset_in_n_cnt_q <= 7'h00;
            end else if (ref_rise && reset_in_n_cnt_q != `CCG_RESET_IN_N_MIN_REF) begin
                reset_in_n_cnt_q <= reset_in_n_cnt_q + 7'h01;
            end
            if (rst_release) begin
                short_rst_q <= (reset_in_n_cnt_q != `CCG_RESET_IN_N_MIN_REF);
            end
        end
    end

    // ratio monitor: core cycles between reference rising edges
    logic [2:0]         ref_gap_q;
    logic               ratio_ok_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_gap_q  <= 3'h0;
            ratio_ok_q <= 1'b0;
        end else if (ref_rise) begin
            ref_gap_q  <= 3'h0;
            ratio_ok_q <= (ref_gap_q == `CCG_CORE_PER_REF - 3'd1);
        end else if (ref_gap_q != 3'h7) begin
            ref_gap_q <= ref_gap_q + 3'h1;
        end
    end

    // control register
    logic [7:0]         ctrl_q;
    wire                ctrl_sel  = (reg_addr == `CCG_CTRL_OFFSET);
    wire                stat_sel  = (reg_addr == `CCG_STAT_OFFSET);
    wire                stop_en   = ctrl_q[`CCG_STOP_EN_BIT];
    wire [2:0]          wake_lvl  = ctrl_q[`CCG_WAKE_MSB:`CCG_WAKE_LSB];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CCG_CTRL_RESET;
        end else if (reg_write && ctrl_sel) begin
            ctrl_q <= reg_wdata & `CCG_CTRL_MASK;
        end
    end

    // wake qualification by decoded interrupt level
    logic               wake_irq;

    always_comb begin
        case (wake_lvl)
            `CCG_WAKE_ANY:  wake_irq = (irq_level != 3'h0);
            `CCG_WAKE_2:    wake_irq = (irq_level >= 3'h2);
            `CCG_WAKE_4:    wake_irq = (irq_level >= 3'h4);
            `CCG_WAKE_5:    wake_irq = (irq_level >= 3'h5);
            `CCG_WAKE_6:    wake_irq = (irq_level >= 3'h6);
            `CCG_WAKE_NONE: wake_irq = 1'b0;
            default:        wake_irq = 1'b0;
        endcase
    end

    wire wake_hit = wake_irq | watchdog_reset;

    // mode sequencer
    ccg_pkg::ccg_mode_type mode_q;
    ccg_pkg::ccg_mode_type mode_d;
    logic [16:0]        lock_cnt_q;

    wire lock_done = ref_rise && (lock_cnt_q == LOCK_LAST);
    wire stop_take = stop_request & stop_en;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            ccg_pkg::mode_reset: begin
                if (rst_release) begin
                    mode_d = ccg_pkg::mode_lock;
                end
            end
            ccg_pkg::mode_lock: begin
                if (lock_done) begin
                    mode_d = ccg_pkg::mode_run;
                end
            end
            ccg_pkg::mode_run: begin
                if (stop_take) begin
                    mode_d = ccg_pkg::mode_stop;
                end
            end
            ccg_pkg::mode_stop: begin
                if (wake_hit) begin
                    mode_d = ccg_pkg::mode_run;
                end
            end
            default: mode_d = ccg_pkg::mode_reset;
        endcase
        if (rst_in_active) begin
            mode_d = ccg_pkg::mode_reset;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= ccg_pkg::mode_reset;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_cnt_q <= 17'h0_0000;
        end else if (mode_q != ccg_pkg::mode_lock) begin
            lock_cnt_q <= 17'h0_0000;
        end else if (ref_rise) begin
            lock_cnt_q <= lock_cnt_q + 17'h0_0001;
        end
    end

    // stop never drops lock, so a wake needs no relock
    wire locked   = (mode_q == ccg_pkg::mode_run) || (mode_q == ccg_pkg::mode_stop);
    wire core_run = (mode_q == ccg_pkg::mode_run);
    assign loop_locked = locked;

    // bus clock divider
    logic [1:0]         div_last;
    logic [1:0]         div_high;

    always_comb begin
        case (ratio_q)
            `CCG_RATIO_HALF: begin
                div_last = 2'h1;
                div_high = 2'h1;
            end
            `CCG_RATIO_THIRD: begin
                div_last = 2'h2;
                div_high = 2'h1;
            end
            default: begin
                div_last = 2'h3;
                div_high = 2'h2;
            end
        endcase
    end

    logic [1:0]         div_cnt_q;
    logic               bus_clk_q;
    wire                div_wrap  = locked && (div_cnt_q == div_last);
    // unlocked, the counter parks on its last value so the first bus period is full length
    wire [1:0]          div_cnt_d = !locked ? div_last : (div_wrap ? 2'h0 : div_cnt_q + 2'h1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= 2'h0;
            bus_clk_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            bus_clk_q <= locked && (div_cnt_d < div_high);
        end
    end

    assign bus_clock_out = bus_clk_q;

    // reset output: low in reset and lock, then a few bus periods more
    logic [4:0]         reset_out_n_cnt_q;
    logic               reset_out_n_n_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_out_n_cnt_q <= 5'h00;
            reset_out_n_n_q   <= 1'b0;
        end else if (!locked || rst_in_active) begin
            reset_out_n_cnt_q <= 5'h00;
            reset_out_n_n_q   <= 1'b0;
        end else if (reset_out_n_cnt_q != `CCG_RESET_OUT_N_BUS_CYCLES) begin
            if (div_wrap) begin
                reset_out_n_cnt_q <= reset_out_n_cnt_q + 5'h01;
            end
        end else begin
            reset_out_n_n_q <= 1'b1;
        end
    end

    assign reset_out_n = reset_out_n_n_q;

    // glitch-free gates: enables change on the falling edge only
    logic               core_gate_q;
    logic               trace_gate_q;

    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            core_gate_q  <= 1'b0;
            trace_gate_q <= 1'b0;
        end else begin
            core_gate_q  <= core_run;
            trace_gate_q <= locked;
        end
    end

    assign core_clock_out     = clk & core_gate_q;
    assign trace_status_clock = clk & trace_gate_q;
    assign core_clock_run     = core_gate_q;

    // register read port, data valid for one cycle
    wire [7:0] stat_word = {locked, (mode_q == ccg_pkg::mode_stop), ratio_ok_q,
                            short_rst_q, range_q, ratio_q};
    wire [7:0] rd_mux    = ctrl_sel ? ctrl_q : (stat_sel ? stat_word : 8'h00);
    logic [7:0]         rdata_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_read ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    // checks
    sequence s_half;
        !bus_clock_out ##1 bus_clock_out;
    endsequence

    sequence s_third;
        !bus_clock_out ##1 !bus_clock_out ##1 bus_clock_out;
    endsequence

    sequence s_quarter;
        bus_clock_out ##1 !bus_clock_out ##1 !bus_clock_out ##1 bus_clock_out;
    endsequence

    property p_bus_half;
        @(posedge clk) disable iff (rst || rst_in_active)
        ($rose(bus_clock_out) && ratio_q == `CCG_RATIO_HALF) |=> s_half;
    endproperty
    a_bus_half: assert property (p_bus_half) else $error("bus clock not half");

    property p_bus_third;
        @(posedge clk) disable iff (rst || rst_in_active)
        ($rose(bus_clock_out) && ratio_q == `CCG_RATIO_THIRD) |=> s_third;
    endproperty
    a_bus_third: assert property (p_bus_third) else $error("bus clock not third");

    property p_bus_quarter;
        @(posedge clk) disable iff (rst || rst_in_active)
        ($rose(bus_clock_out) && ratio_q == `CCG_RATIO_QUARTER) |=> s_quarter;
    endproperty
    a_bus_quarter: assert property (p_bus_quarter) else $error("bus clock not quarter");

    property p_low_until_lock;
        @(posedge clk) disable iff (rst)
        (!locked ##1 !locked) |-> (!bus_clock_out && !trace_gate_q);
    endproperty
    a_low_until_lock: assert property (p_low_until_lock) else $error("clock before lock");

    property p_reset_out_n_in_reset;
        @(posedge clk) disable iff (rst)
        rst_in_active |=> !reset_out_n [*2];
    endproperty
    a_reset_out_n_in_reset: assert property (p_reset_out_n_in_reset) else $error("reset out high");

    property p_stop_gates;
        @(posedge clk) disable iff (rst || rst_in_active)
        (core_run && stop_take && !rst_in_active) |-> ##1 !core_clock_run;
    endproperty
    a_stop_gates: assert property (p_stop_gates) else $error("core not gated");

    property p_stop_disabled;
        @(posedge clk) disable iff (rst || rst_in_active)
        (core_run && stop_request && !stop_en) |-> ##2 core_clock_run;
    endproperty
    a_stop_disabled: assert property (p_stop_disabled) else $error("gated while disabled");

    property p_wake_none;
        @(posedge clk) disable iff (rst || rst_in_active)
        (mode_q == ccg_pkg::mode_stop && wake_lvl == `CCG_WAKE_NONE && !watchdog_reset)
            |=> (mode_q == ccg_pkg::mode_stop);
    endproperty
    a_wake_none: assert property (p_wake_none) else $error("woke at level none");

    property p_wake_quick;
        @(posedge clk) disable iff (rst || rst_in_active)
        (mode_q == ccg_pkg::mode_stop && wake_hit) |-> ##1 core_clock_run;
    endproperty
    a_wake_quick: assert property (p_wake_quick) else $error("slow wake");

    property p_wake_four;
        @(posedge clk) disable iff (rst || rst_in_active)
        (mode_q == ccg_pkg::mode_stop && wake_lvl == `CCG_WAKE_4 && irq_level == 3'h3
            && !watchdog_reset) |=> (mode_q == ccg_pkg::mode_stop);
    endproperty
    a_wake_four: assert property (p_wake_four) else $error("level 3 woke core");

    property p_straps_fixed;
        @(posedge clk) disable iff (rst || rst_in_active)
        locked |=> ($stable(ratio_q) && $stable(range_q));
    endproperty
    a_straps_fixed: assert property (p_straps_fixed) else $error("strap changed");

    property p_ctrl_kept;
        @(posedge clk) disable iff (rst)
        (mode_q == ccg_pkg::mode_stop && !reg_write) |=> $stable(ctrl_q);
    endproperty
    a_ctrl_kept: assert property (p_ctrl_kept) else $error("control lost in stop");

endmodule : ccg_top

// *** bench/ccg_core_model.sv ***
`timescale 1ns/1ps

module ccg_core_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       core_clock_run,
    output logic            stop_request,
    output logic      [2:0] irq_level
);
    initial begin
        stop_request = 1'b0;
        irq_level = 3'h0;
    end

    // a stopped core executes nothing, so the stop is only issued while clocked
    task automatic exec_stop();
        @(posedge clk);
        while (core_clock_run !== 1'b1 || rst !== 1'b0) @(posedge clk);
        stop_request <= 1'b1;
        @(posedge clk);
        stop_request <= 1'b0;
    endtask : exec_stop

    // decoded pending priority, held as a level until changed
    task automatic set_irq(input logic [2:0] lvl);
        @(posedge clk);
        irq_level <= lvl;
    endtask : set_irq
endmodule : ccg_core_model

// *** bench/ccg_top_test.sv ***
`timescale 1ns/1ps
`include "ccg_defines.svh"

module ccg_top_test;
    logic       clk;
    logic       rst;
    logic       ref_clock_in;
    logic       reset_in_n;
    logic [3:0] data_pins;
    logic       stop_request;
    logic [2:0] irq_level;
    logic       watchdog_reset;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    logic       core_clock_out;
    logic       core_clock_run;
    logic       trace_status_clock;
    logic       bus_clock_out;
    logic       reset_out_n;
    logic [1:0] loop_range;
    logic       loop_locked;
    int         err_count;
    int         samples_checked;
    int         cycles;
    int         ref_cnt;
    int         core_cnt;
    int         trace_cnt;
    int         bus_cnt;

    ccg_top #(.LOCK_REF_CYCLES(20)) ccg_top_i (
        .clk(clk), .rst(rst), .ref_clock_in(ref_clock_in), .reset_in_n(reset_in_n),
        .data_pins(data_pins), .stop_request(stop_request), .irq_level(irq_level),
        .watchdog_reset(watchdog_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .core_clock_out(core_clock_out), .core_clock_run(core_clock_run),
        .trace_status_clock(trace_status_clock), .bus_clock_out(bus_clock_out),
        .reset_out_n(reset_out_n), .loop_range(loop_range), .loop_locked(loop_locked)
    );

    ccg_core_model ccg_core_model_i (
        .clk(clk), .rst(rst), .core_clock_run(core_clock_run),
        .stop_request(stop_request), .irq_level(irq_level)
    );

    always #5 clk = ~clk;
    // reference at half the core rate, phase unrelated to clk
    initial begin
        ref_clock_in = 1'b0;
        #3;
        forever #10 ref_clock_in = ~ref_clock_in;
    end
    always @(posedge ref_clock_in) ref_cnt++;
    always @(posedge core_clock_out) core_cnt++;
    always @(posedge trace_status_clock) trace_cnt++;
    always @(posedge bus_clock_out) bus_cnt++;

    task automatic results();
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_rd

    task automatic clk_wait(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : clk_wait

    // count clk cycles between two rises of the bus clock
    task automatic bus_period(output int n);
        int first;
        logic p;
        first = -1;
        n = 0;
        p = 1'b1;
        for (int k = 0; k < 24; k++) begin
            clk_wait(1);
            if (bus_clock_out === 1'b1 && p === 1'b0) begin
                if (first < 0) first = k;
                else if (n == 0) n = k - first;
            end
            p = bus_clock_out;
        end
    endtask : bus_period

    // pin reset with straps, then lock and check the divided and traced clocks
    task automatic cfg_reset(input logic [1:0] rng, input logic [1:0] rat, input int div);
        int n;
        logic [7:0] d;
        @(posedge clk);
        data_pins <= {rng, rat};
        reset_in_n <= 1'b0;
        clk_wait(170);
        chk("reset_out_n", 0, reset_out_n);
        chk("locked_in_reset", 0, loop_locked);
        @(posedge clk);
        reset_in_n <= 1'b1;
        clk_wait(8);
        data_pins <= ~{rng, rat};
        chk("bus_before_lock", 0, bus_clock_out);
        chk("trace_before_lock", 0, trace_status_clock);
        n = 0;
        while (loop_locked !== 1'b1 && n < 200) begin
            clk_wait(1);
            n++;
        end
        chk("loop_locked", 1, loop_locked);
        chk("loop_range", {30'h0, rng}, {30'h0, loop_range});
        bus_period(n);
        chk("bus_period", div, n);
        ref_cnt = 0;
        core_cnt = 0;
        trace_cnt = 0;
        clk_wait(40);
        chk("core_vs_ref", 2 * ref_cnt, core_cnt);
        chk("trace_vs_core", core_cnt, trace_cnt);
        n = 0;
        while (reset_out_n !== 1'b1 && n < 300) begin
            clk_wait(1);
            n++;
        end
        chk("reset_out_release", 1, reset_out_n);
        // locked, running, reference at half rate, long enough reset, straps as driven
        reg_rd(`CCG_STAT_OFFSET, d);
        chk("status", {1'b1, 1'b0, 1'b1, 1'b0, rng, rat}, d);
    endtask : cfg_reset

    task automatic reg_checks();
        logic [7:0] d;
        reg_rd(`CCG_CTRL_OFFSET, d);
        chk("ctrl_reset", `CCG_CTRL_RESET, d);
        reg_wr(`CCG_CTRL_OFFSET, 8'hFF);
        reg_rd(`CCG_CTRL_OFFSET, d);
        chk("ctrl_rw", 8'hF0, d);
        reg_rd(8'h08, d);
        chk("unmapped", 0, d);
    endtask : reg_checks

    // stop with the enable clear must not gate the core
    task automatic stop_disabled();
        reg_wr(`CCG_CTRL_OFFSET, 8'h70);
        ccg_core_model_i.exec_stop();
        clk_wait(4);
        chk("run_no_enable", 1, core_clock_run);
    endtask : stop_disabled

    task automatic stop_wake(input logic [2:0] fld, input logic [2:0] below,
                             input logic [2:0] wake, input logic use_dog);
        logic [7:0] d;
        reg_wr(`CCG_CTRL_OFFSET, {1'b1, fld, 4'h0});
        ccg_core_model_i.exec_stop();
        clk_wait(2);
        chk("run_stopped", 0, core_clock_run);
        bus_cnt = 0;
        ccg_core_model_i.set_irq(below);
        clk_wait(11);
        chk("still_stopped", 0, core_clock_run);
        chk("bus_in_stop", 6, bus_cnt);
        chk("lock_in_stop", 1, loop_locked);
        if (use_dog) begin
            @(posedge clk);
            watchdog_reset <= 1'b1;
            @(posedge clk);
            watchdog_reset <= 1'b0;
            clk_wait(2);
            chk("dog_wake", 1, core_clock_run);
        end else begin
            ccg_core_model_i.set_irq(wake);
            clk_wait(3);
            chk("irq_wake", 1, core_clock_run);
        end
        ccg_core_model_i.set_irq(3'h0);
        reg_rd(`CCG_CTRL_OFFSET, d);
        chk("ctrl_kept", {1'b1, fld, 4'h0}, d);
    endtask : stop_wake

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reset_in_n = 1'b0;
        data_pins = 4'h0;
        watchdog_reset = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        reg_checks();
        cfg_reset(2'h0, `CCG_RATIO_QUARTER, 4);
        cfg_reset(2'h1, `CCG_RATIO_THIRD, 3);
        cfg_reset(2'h2, `CCG_RATIO_HALF, 2);
        stop_disabled();
        stop_wake(`CCG_WAKE_ANY, 3'h0, 3'h1, 1'b0);
        stop_wake(`CCG_WAKE_2, 3'h1, 3'h2, 1'b0);
        stop_wake(`CCG_WAKE_4, 3'h3, 3'h4, 1'b0);
        stop_wake(`CCG_WAKE_5, 3'h4, 3'h5, 1'b0);
        stop_wake(`CCG_WAKE_6, 3'h5, 3'h6, 1'b0);
        stop_wake(`CCG_WAKE_NONE, 3'h7, 3'h0, 1'b1);
        results();
    end
endmodule : ccg_top_test
